/* rtl/rsfbc_top.sv */
// sampling, bartlett filter, decimator and bias calibration of a rate sensor
// Operation
// (RL1) internal rate is 32768/(code+1) samples per second, at most 2048
// (RL2) code resets to 1024 sps; nonzero codes below 0x000F are not allowed
// (RL3) code zero takes sample timing from the external clock pin
// (RL4) two averaging stages in cascade give a bartlett response
// (RL5) tap exponent in bits 2:0, max 6, 2^exp taps, upper bits ignored
// (RL6) tap exponent 4 gives sixteen taps per stage
// (RL7) decimation exponent in bits 4:0, max 16, upper bits ignored
// (RL8) last stage averages and decimates by two to the exponent
// (RL9) exponent 0x10 averages 65536 samples per output
// (RL10) command bit 0 starts automatic bias null
// (RL11) null: full decimated cycle, negate output, load offsets, update nv
// (RL12) serial frames ignored while null runs; only reset aborts it
// (RL13) host keeps platform still 65 s for the largest decimation
// (RL14) coarse offset, upper output format, added to rate output
// (RL15) fine offset, lower output format, added with the coarse one
// (RL16) command bit 1 zeroes calibration and data, nv update within 72 ms
// (RL17) registers written a byte per frame, low byte at even address
// (RL18) each stage sums 2^exp samples and shifts right by exp
`timescale 1ns/100ps
`include "rsfbc_defs.svh"
module rsfbc_top
  import rsfbc_pkg::*;
#(
  parameter int unsigned NV_CYCLES = `RSFBC_NV_CYCLES
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial port, link clock domain
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // external sample clock pin
  input  wire logic        external_sample_clock_in,
  // raw sensor samples
  output logic             sample_strobe,
  input  wire rsfbc_rate_t raw_rate,
  // corrected rate stream
  output logic             rate_valid,
  input  wire logic        rate_ready,
  output rsfbc_rate_t      rate_data,
  // nonvolatile update in progress
  output logic             nv_update_busy
);

  // link domain state
  logic [3:0]   bit_cnt_q;
  logic [15:0]  rx_sh_q;
  logic [15:0]  rx_word_q;
  logic [15:0]  tx_q;
  logic         rx_tgl_q;
  // core state
  logic [15:0]  rd_word_q;
  logic [2:0]   rx_sync_q;
  logic [15:0]  bias_fine_q;
  logic [15:0]  bias_coarse_q;
  logic [15:0]  smpl_q;
  logic [15:0]  tap_q;
  logic [15:0]  dec_q;
  rsfbc_rate_t  rate_out_q;
  rsfbc_cal_t   cal_q;
  logic [23:0]  nv_cnt_q;
  logic [27:0]  frac_q;
  logic [15:0]  per_cnt_q;
  logic [2:0]   ext_sync_q;
  logic [3:0]   pipe_q;
  logic         flush_q;
  rsfbc_rate_t  x_q;
  rsfbc_rate_t  y1_q;
  logic signed [37:0] s1_sum_q;
  logic signed [37:0] s2_sum_q;
  logic signed [47:0] dec_sum_q;
  logic [16:0]  dcnt_q;
  logic [5:0]   wp1_q;
  logic [5:0]   wp2_q;
  logic [6:0]   fill1_q;
  logic [6:0]   fill2_q;
  rsfbc_rate_t  buf_q [2];
  logic         buf_wp_q;
  logic         buf_rp_q;
  logic [1:0]   buf_cnt_q;
  // combinational
  rsfbc_frame_t frm;
  logic         frame_ev;
  logic         frame_ok;
  logic         wr_ev;
  logic         start_null;
  logic         start_restore;
  logic [15:0]  rd_mux;
  logic [2:0]   taps;
  logic [4:0]   dexp;
  logic [6:0]   ntap;
  logic [16:0]  dlen;
  logic [15:0]  code_eff;
  logic [27:0]  frac_sum;
  logic         base_tick;
  logic         int_tick;
  logic         ext_tick;
  logic         take;
  rsfbc_rate_t  rd1;
  rsfbc_rate_t  rd2;
  rsfbc_rate_t  old1;
  rsfbc_rate_t  old2;
  rsfbc_rate_t  y2;
  rsfbc_rate_t  avg;
  rsfbc_rate_t  corr;
  logic         dec_last;
  logic         push;
  logic         pop;
  logic         buf_full;

  // link side: frame bit counter restarts whenever chip select rises
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      bit_cnt_q <= 4'h0;
    else
      bit_cnt_q <= bit_cnt_q + 4'h1;
  end

  // link side: shift in sixteen bits, hand the word over by a toggle
  always_ff @(posedge spi_sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_sh_q   <= 16'h0000;
      rx_word_q <= 16'h0000;
      rx_tgl_q  <= 1'b0;
    end
    else
    begin
      rx_sh_q <= {rx_sh_q[14:0], spi_mosi};
      if (bit_cnt_q == 4'hF)
      begin
        rx_word_q <= {rx_sh_q[14:0], spi_mosi};
        rx_tgl_q  <= ~rx_tgl_q;
      end
    end
  end

  // link side: read word is held still by the core between frames
  always_ff @(posedge spi_sclk or negedge nrst)
  begin
    if (!nrst)
      tx_q <= 16'h0000;
    else if (bit_cnt_q == 4'h0)
      tx_q <= {rd_word_q[14:0], 1'b0};
    else
      tx_q <= {tx_q[14:0], 1'b0};
  end

  assign spi_miso    = (bit_cnt_q == 4'h0) ? rd_word_q[15] : tx_q[15];
  assign spi_miso_oe = ~spi_cs_n;

  // core side: toggle crossing, word is stable once the toggle is seen
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rx_sync_q <= 3'h0;
    else
      rx_sync_q <= {rx_sync_q[1:0], rx_tgl_q};
  end

  assign frame_ev = rx_sync_q[2] ^ rx_sync_q[1];
  assign frm      = rsfbc_frame_t'(rx_word_q);
  assign frame_ok = frame_ev && (cal_q == CAL_IDLE);   // see (RL12)
  assign wr_ev    = frame_ok && frm.wr;
  assign start_null    = wr_ev && (frm.addr == `RSFBC_ADR_CMD) &&
                         frm.data[`RSFBC_CMD_NULL];    // see (RL10)
  assign start_restore = wr_ev && (frm.addr == `RSFBC_ADR_CMD) &&
                         frm.data[`RSFBC_CMD_RESTORE]; // see (RL16)

  // read decode on the even address; unmapped and write-only read zero
  always_comb
  begin
    case ({frm.addr[6:1], 1'b0})
      `RSFBC_ADR_OUT_LO:      rd_mux = rate_out_q[15:0];
      `RSFBC_ADR_OUT_HI:      rd_mux = rate_out_q[31:16];
      `RSFBC_ADR_BIAS_FINE:   rd_mux = bias_fine_q;
      `RSFBC_ADR_BIAS_COARSE: rd_mux = bias_coarse_q;
      `RSFBC_ADR_SMPL:        rd_mux = smpl_q;
      `RSFBC_ADR_TAP:         rd_mux = tap_q;
      `RSFBC_ADR_DEC:         rd_mux = dec_q;
      default:                rd_mux = 16'h0000;
    endcase
  end

  // a read frame loads the word shifted out by the next frame
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_word_q <= 16'h0000;
    else if (frame_ok && !frm.wr)
      rd_word_q <= rd_mux;
  end

  // filter configuration, one byte lane per frame
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      smpl_q <= `RSFBC_RST_SMPL;                       // see (RL2)
      tap_q  <= `RSFBC_RST_ZERO;
      dec_q  <= `RSFBC_RST_ZERO;
    end
    else if (wr_ev)
    begin
      case (frm.addr)                                  // see (RL17)
        `RSFBC_ADR_SMPL:         smpl_q[7:0]  <= frm.data;
        `RSFBC_ADR_SMPL + 7'h01: smpl_q[15:8] <= frm.data;
        `RSFBC_ADR_TAP:          tap_q[7:0]   <= frm.data;
        `RSFBC_ADR_TAP + 7'h01:  tap_q[15:8]  <= frm.data;
        `RSFBC_ADR_DEC:          dec_q[7:0]   <= frm.data;
        `RSFBC_ADR_DEC + 7'h01:  dec_q[15:8]  <= frm.data;
        default:                 smpl_q       <= smpl_q;
      endcase
    end
  end

  // offsets: restore beats the null result, which beats a host write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bias_fine_q   <= `RSFBC_RST_ZERO;
      bias_coarse_q <= `RSFBC_RST_ZERO;
    end
    else if (start_restore)
    begin
      bias_fine_q   <= `RSFBC_RST_ZERO;                // see (RL16)
      bias_coarse_q <= `RSFBC_RST_ZERO;
    end
    else if (cal_q == CAL_WAIT && push)
    begin
      bias_fine_q   <= 16'(-corr);                     // see (RL11)
      bias_coarse_q <= 16'((-corr) >>> 16);
    end
    else if (wr_ev)
    begin
      case (frm.addr)                                  // see (RL17)
        `RSFBC_ADR_BIAS_FINE:          bias_fine_q[7:0]    <= frm.data;
        `RSFBC_ADR_BIAS_FINE + 7'h01:  bias_fine_q[15:8]   <= frm.data;
        `RSFBC_ADR_BIAS_COARSE:        bias_coarse_q[7:0]  <= frm.data;
        `RSFBC_ADR_BIAS_COARSE + 7'h01: bias_coarse_q[15:8] <= frm.data;
        default:                       bias_fine_q         <= bias_fine_q;
      endcase
    end
  end

  // calibration sequencer; the long nv wait is shortened by NV_CYCLES
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_q    <= CAL_IDLE;
      nv_cnt_q <= 24'h000000;
    end
    else
    begin
      case (cal_q)
        CAL_IDLE:
        begin
          nv_cnt_q <= 24'h000000;
          if (start_restore)
            cal_q <= CAL_FLASH;                        // see (RL16)
          else if (start_null)
            cal_q <= CAL_WAIT;                         // see (RL11)
        end
        CAL_WAIT:
        begin
          if (push)
            cal_q <= CAL_FLASH;                        // see (RL11)
        end
        CAL_FLASH:
        begin
          nv_cnt_q <= nv_cnt_q + 24'h000001;
          if (nv_cnt_q == 24'(NV_CYCLES - 1))
            cal_q <= CAL_IDLE;
        end
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end

  assign nv_update_busy = (cal_q == CAL_FLASH);

  // clamp the exponents; bits above the fields are ignored
  assign taps = (tap_q[`RSFBC_TAP_MSB:0] > `RSFBC_TAP_MAX) ?
                `RSFBC_TAP_MAX : tap_q[`RSFBC_TAP_MSB:0];   // see (RL5)
  assign dexp = (dec_q[`RSFBC_DEC_MSB:0] > `RSFBC_DEC_MAX) ?
                `RSFBC_DEC_MAX : dec_q[`RSFBC_DEC_MSB:0];   // see (RL7)
  assign ntap = 7'h01 << taps;                          // see (RL6)
  assign dlen = 17'h00001 << dexp;                      // see (RL9)
  assign code_eff = (smpl_q < `RSFBC_SMPL_MIN) ? `RSFBC_SMPL_MIN : smpl_q;

  // exact 32768 hz base tick from a fractional accumulator
  assign frac_sum  = frac_q + `RSFBC_BASE_HZ;
  assign base_tick = (frac_sum >= `RSFBC_CLK_HZ);
  assign int_tick  = base_tick && (per_cnt_q >= code_eff);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frac_q    <= 28'h0000000;
      per_cnt_q <= 16'h0000;
    end
    else
    begin
      frac_q <= base_tick ? frac_sum - `RSFBC_CLK_HZ : frac_sum;
      if (int_tick)
        per_cnt_q <= 16'h0000;                          // see (RL1)
      else if (base_tick)
        per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end

  // pin is synchronised twice before the edge detector reads it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ext_sync_q <= 3'h0;
    else
      ext_sync_q <= {ext_sync_q[1:0], external_sample_clock_in};
  end

  assign ext_tick = ext_sync_q[1] & ~ext_sync_q[2];

  // a sample is skipped while the output buffer is full
  assign take = ((smpl_q == `RSFBC_SMPL_EXT) ? ext_tick : int_tick) &&
                !buf_full && (pipe_q == 4'h0) && !flush_q;  // see (RL3)
  assign sample_strobe = take;

  // a tap or decimation write, a null or a restore restarts all averages
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flush_q <= 1'b0;
    else
      flush_q <= start_null || start_restore ||
                 (wr_ev && ({frm.addr[6:1], 1'b0} == `RSFBC_ADR_TAP ||
                            {frm.addr[6:1], 1'b0} == `RSFBC_ADR_DEC));
  end

  rsfbc_mem u_hist1 (
    .clk       (clk),
    .wr_en     (take),
    .wr_addr   (wp1_q),
    .wr_data   (raw_rate),
    .rd_addr   (wp1_q - ntap[5:0]),
    .rd_data_q (rd1)
  );

  rsfbc_mem u_hist2 (
    .clk       (clk),
    .wr_en     (pipe_q[1]),
    .wr_addr   (wp2_q),
    .wr_data   (32'(s1_sum_q >>> taps)),
    .rd_addr   (wp2_q - ntap[5:0]),
    .rd_data_q (rd2)
  );

  // history reads count as zero until a stage has seen ntap samples
  assign old1 = (fill1_q == ntap) ? rd1 : 32'h00000000;
  assign old2 = (fill2_q == ntap) ? rd2 : 32'h00000000;
  assign y2   = 32'(s2_sum_q >>> taps);                 // see (RL18)
  assign dec_last = (dcnt_q == dlen - 17'h00001);
  assign avg  = 32'((dec_sum_q + 48'(y2)) >>> dexp);    // see (RL8)
  assign corr = avg + $signed({bias_coarse_q, bias_fine_q}); // see (RL14)
  // no publish while a restart is pending: null must see a fresh average
  assign push = pipe_q[3] && dec_last && !flush_q && !start_restore;

  // two moving sums in cascade: boxcar into boxcar is a triangle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pipe_q   <= 4'h0;
      x_q      <= 32'h00000000;
      y1_q     <= 32'h00000000;
      s1_sum_q <= 38'h0000000000;
      s2_sum_q <= 38'h0000000000;
      wp1_q    <= 6'h00;
      wp2_q    <= 6'h00;
      fill1_q  <= 7'h00;
      fill2_q  <= 7'h00;
    end
    else if (flush_q)
    begin
      pipe_q   <= 4'h0;
      s1_sum_q <= 38'h0000000000;
      s2_sum_q <= 38'h0000000000;
      fill1_q  <= 7'h00;
      fill2_q  <= 7'h00;
    end
    else
    begin
      pipe_q <= {pipe_q[2:0], take};
      if (take)
      begin
        x_q   <= raw_rate;
        wp1_q <= wp1_q + 6'h01;
      end
      if (pipe_q[0])
      begin
        s1_sum_q <= s1_sum_q + 38'(x_q) - 38'(old1);   // see (RL4)
        fill1_q  <= (fill1_q == ntap) ? fill1_q : fill1_q + 7'h01;
      end
      if (pipe_q[1])
      begin
        y1_q  <= 32'(s1_sum_q >>> taps);                // see (RL18)
        wp2_q <= wp2_q + 6'h01;
      end
      if (pipe_q[2])
      begin
        s2_sum_q <= s2_sum_q + 38'(y1_q) - 38'(old2);  // see (RL4)
        fill2_q  <= (fill2_q == ntap) ? fill2_q : fill2_q + 7'h01;
      end
    end
  end

  // average and decimate, then correct and publish the rate
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dec_sum_q  <= 48'h000000000000;
      dcnt_q     <= 17'h00000;
      rate_out_q <= 32'h00000000;
    end
    else if (start_restore)
    begin
      dec_sum_q  <= 48'h000000000000;
      dcnt_q     <= 17'h00000;
      rate_out_q <= 32'h00000000;                       // see (RL16)
    end
    else if (flush_q)
    begin
      dec_sum_q <= 48'h000000000000;
      dcnt_q    <= 17'h00000;
    end
    else if (pipe_q[3])
    begin
      if (dec_last)
      begin
        dec_sum_q  <= 48'h000000000000;
        dcnt_q     <= 17'h00000;
        rate_out_q <= corr;                             // see (RL15)
      end
      else
      begin
        dec_sum_q <= dec_sum_q + 48'(y2);              // see (RL8)
        dcnt_q    <= dcnt_q + 17'h00001;
      end
    end
  end

  // two-entry output buffer; a stalled reader holds off new samples
  assign buf_full   = (buf_cnt_q == 2'h2);
  assign rate_valid = (buf_cnt_q != 2'h0);
  assign rate_data  = buf_q[buf_rp_q];
  assign pop        = rate_valid && rate_ready;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_q[0]  <= 32'h00000000;
      buf_q[1]  <= 32'h00000000;
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        buf_q[buf_wp_q] <= corr;
        buf_wp_q        <= ~buf_wp_q;
      end
      if (pop)
        buf_rp_q <= ~buf_rp_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : rsfbc_top

/* rtl/rsfbc_defs.svh */
// offsets, field positions, reset values and timing counts of the filter
`ifndef RSFBC_DEFS_SVH
`define RSFBC_DEFS_SVH

// register byte addresses (low byte of each 16-bit register)
`define RSFBC_ADR_OUT_LO      7'h04
`define RSFBC_ADR_OUT_HI      7'h06
`define RSFBC_ADR_BIAS_FINE   7'h08
`define RSFBC_ADR_BIAS_COARSE 7'h0A
`define RSFBC_ADR_SMPL        7'h1E
`define RSFBC_ADR_TAP         7'h20
`define RSFBC_ADR_DEC         7'h22
`define RSFBC_ADR_CMD         7'h28

// reset values and limits
`define RSFBC_RST_SMPL        16'h001F
`define RSFBC_RST_ZERO        16'h0000
`define RSFBC_SMPL_EXT        16'h0000
`define RSFBC_SMPL_MIN        16'h000F
`define RSFBC_TAP_MAX         3'h6
`define RSFBC_DEC_MAX         5'h10

// field positions
`define RSFBC_CMD_NULL        0
`define RSFBC_CMD_RESTORE     1
`define RSFBC_TAP_MSB         2
`define RSFBC_DEC_MSB         4

// timing
`define RSFBC_CLK_HZ          28'h7735940
`define RSFBC_BASE_HZ         28'h0008000
`define RSFBC_CLK_PERIOD_NS   8
`define RSFBC_NV_TIME_MS      72
`define RSFBC_NV_CYCLES \
  ((`RSFBC_NV_TIME_MS * 1000000) / `RSFBC_CLK_PERIOD_NS)

`endif

/* rtl/rsfbc_pkg.sv */
// types shared by the rate filter files
package rsfbc_pkg;

  // one serial frame: write flag, byte address, data byte
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } rsfbc_frame_t;

  // calibration sequencer, gray along idle -> wait -> flash
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'h0,
    CAL_WAIT  = 2'h1,
    CAL_FLASH = 2'h3
  } rsfbc_cal_t;

  typedef logic signed [31:0] rsfbc_rate_t;

endpackage : rsfbc_pkg

/* rtl/rsfbc_mem.sv */
// sample history memory for one averaging stage, registered read
`timescale 1ns/100ps
module rsfbc_mem
  import rsfbc_pkg::*;
(
  // clock
  input  wire logic        clk,
  // write side
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_addr,
  input  wire rsfbc_rate_t wr_data,
  // read side
  input  wire logic [5:0]  rd_addr,
  output rsfbc_rate_t      rd_data_q
);

  rsfbc_rate_t mem_q [64];

  // read sees the old word when both ports hit one address
  always_ff @(posedge clk)
  begin
    rd_data_q <= mem_q[rd_addr];
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

endmodule : rsfbc_mem

/* testbench/rsfbc_monitor.sv */
// concurrent port checks for the rate filter
`timescale 1ns/100ps
module rsfbc_monitor
  import rsfbc_pkg::*;
#(
  parameter int unsigned NV_CYCLES = 20
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // serial port
  input wire logic        spi_cs_n,
  input wire logic        spi_miso_oe,
  // sample and stream
  input wire logic        sample_strobe,
  input wire logic        rate_valid,
  input wire logic        rate_ready,
  input wire rsfbc_rate_t rate_data,
  // nonvolatile update
  input wire logic        nv_update_busy
);
  int unsigned busy_cnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // length of the running busy period, zero when idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busy_cnt_q <= 0;
    else
      busy_cnt_q <= nv_update_busy ? busy_cnt_q + 1 : 0;
  end

  chk_oe_follows_cs: assert property (
    spi_miso_oe == !spi_cs_n) else $error("miso enable wrong");
  chk_strobe_gap: assert property (
    sample_strobe |=> !sample_strobe [*3]) else $error("strobes close");
  chk_push_delay: assert property (
    $rose(rate_valid) |-> $past(sample_strobe, 5))
    else $error("word pushed without strobe");
  chk_word_held: assert property (
    rate_valid && !rate_ready |=> rate_valid && $stable(rate_data))
    else $error("stalled word lost");
  chk_pop_only: assert property (
    $fell(rate_valid) |-> $past(rate_ready)) else $error("word dropped");
  chk_busy_bound: assert property (
    nv_update_busy |-> busy_cnt_q <= NV_CYCLES + 1)
    else $error("update too long");
  chk_busy_length: assert property (
    $fell(nv_update_busy) |-> busy_cnt_q >= NV_CYCLES - 1)
    else $error("update too short");
  chk_busy_hold: assert property (
    $rose(nv_update_busy) |-> nv_update_busy [*8])
    else $error("busy glitch");

  cov_stall: cover property (rate_valid && !rate_ready);
  cov_busy: cover property ($fell(nv_update_busy));
  cov_frame: cover property ($fell(spi_cs_n));
endmodule : rsfbc_monitor

bind rsfbc_top rsfbc_monitor #(.NV_CYCLES(NV_CYCLES)) u_mon (
  .clk(clk), .nrst(nrst), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe), .sample_strobe(sample_strobe),
  .rate_valid(rate_valid), .rate_ready(rate_ready),
  .rate_data(rate_data), .nv_update_busy(nv_update_busy));

/* testbench/rsfbc_host.sv */
// host model sending byte frames on the serial port
`timescale 1ns/100ps
module rsfbc_host
(
  // serial lines
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  // idle: clock high, deselected
  initial
  begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // one frame carries one register byte, msb first
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #5.3;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk = 1'b0;
      spi_mosi = w[i];
      #32;
      r[i] = spi_miso_oe ? spi_miso : 1'b1;
      spi_sclk = 1'b1;
      #32;
    end
    spi_cs_n = 1'b1;
    // released line must not look like held data
    spi_mosi = ~spi_mosi;
    #120;
  endtask : xfer
endmodule : rsfbc_host

/* testbench/tb.sv */
// self-checking bench for the rate filter and bias calibration
`timescale 1ns/100ps
module tb
  import rsfbc_pkg::*;
;
  logic        clk, nrst, external_sample_clock_in, sample_strobe;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic        rate_valid, rate_ready, nv_update_busy;
  rsfbc_rate_t raw_rate, rate_data, off, cval;
  rsfbc_rate_t exp_q[$];
  logic [31:0] seed;
  int          num_errors, check_count, cyc, nstrobe, n0, tcnt, te, de;
  int          h[2][64];
  longint      acc;
  int          dcnt;
  bit          ticking, stall, loose, cmode;
  logic [7:0]  tcfg[4] = '{8'h00, 8'h0C, 8'h07, 8'h04};
  logic [7:0]  dcfg[4] = '{8'h00, 8'h21, 8'h02, 8'h04};

  rsfbc_top #(.NV_CYCLES(40)) u_dut (.clk, .nrst, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_miso, .spi_miso_oe, .external_sample_clock_in,
    .sample_strobe, .raw_rate, .rate_valid, .rate_ready, .rate_data,
    .nv_update_busy);
  rsfbc_host u_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe);

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [15:0] r;
    u_host.xfer({1'b1, a, v}, r);
  endtask : wr

  // read word arrives in the frame after the request
  task automatic rdc(input logic [6:0] a, input logic [15:0] x);
    logic [15:0] r;
    u_host.xfer({1'b0, a, 8'h00}, r);
    u_host.xfer(16'h0000, r);
    chk({16'h0000, r}, {16'h0000, x});
  endtask : rdc

  // new filter settings also restart the model's history
  task automatic cfg(input logic [7:0] t, input logic [7:0] dv);
    wr(7'h20, t);
    wr(7'h22, dv);
    te = (t[2:0] > 6) ? 6 : t[2:0];
    de = (dv[4:0] > 16) ? 16 : dv[4:0];
    h = '{default: 0};
    acc = 0;
    dcnt = 0;
  endtask : cfg

  // two moving sums, then average and decimate, then offset
  task automatic step(input rsfbc_rate_t x);
    longint s, v;
    v = x;
    for (int k = 0; k < 2; k++)
    begin
      s = 0;
      for (int i = 63; i > 0; i--)
        h[k][i] = h[k][i-1];
      h[k][0] = int'(v);
      for (int i = 0; i < (1 << te); i++)
        s += h[k][i];
      v = s >>> te;
    end
    acc += v;
    dcnt++;
    if (dcnt == (1 << de))
    begin
      exp_q.push_back(rsfbc_rate_t'(acc >>> de) + off);
      acc = 0;
      dcnt = 0;
    end
  endtask : step

  task automatic run(input int n);
    ticking <= 1'b1;
    repeat (n * 24) @(posedge clk);
    ticking <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : run

  task automatic drain();
    for (int i = 0; i < 300 && rate_valid; i++)
      @(posedge clk);
  endtask : drain

  task automatic wait_busy();
    for (int i = 0; i < 3000 && !nv_update_busy; i++)
      @(posedge clk);
    chk(nv_update_busy, 1'b1);
    for (int i = 0; i < 100 && nv_update_busy; i++)
      @(posedge clk);
    chk(nv_update_busy, 1'b0);
  endtask : wait_busy

  // external sample pin, one tick every 24 cycles
  always @(posedge clk)
  begin
    tcnt <= (tcnt == 23) ? 0 : tcnt + 1;
    external_sample_clock_in <= ticking && tcnt < 12;
  end

  // sample driver notes what each taken sample should produce
  always @(posedge clk)
  begin
    if (nrst && sample_strobe)
    begin
      nstrobe++;
      step(raw_rate);
      raw_rate <= cmode ? cval : rsfbc_rate_t'($signed(rnd()) >>> 12);
    end
  end

  // random consumer stalls unless held off
  always @(posedge clk)
    rate_ready <= !stall && rnd() > 32'h7FFFFFFF;

  // each accepted word is matched to the oldest note; while loose, the notes are dropped instead
  always @(posedge clk)
  begin
    if (nrst && rate_valid && rate_ready)
    begin
      if (loose)
        exp_q = {};
      else if (exp_q.size() == 0)
        chk(rate_data, 32'hX);
      else
        chk(rate_data, exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      test_done();
    end
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    seed = 55566;
    raw_rate = 0;
    rate_ready = 1'b0;
    external_sample_clock_in = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values, write-only command and unmapped place
    rdc(7'h08, 16'h0000);
    rdc(7'h0A, 16'h0000);
    rdc(7'h1E, 16'h001F);
    rdc(7'h20, 16'h0000);
    rdc(7'h22, 16'h0000);
    rdc(7'h28, 16'h0000);
    rdc(7'h30, 16'h0000);
    // offsets byte by byte, low byte at the even address
    off = rnd();
    wr(7'h08, off[7:0]);
    wr(7'h09, off[15:8]);
    wr(7'h0A, off[23:16]);
    wr(7'h0B, off[31:24]);
    rdc(7'h08, off[15:0]);
    rdc(7'h0A, off[31:16]);
    // high byte first so no illegal nonzero code appears
    wr(7'h1F, 8'h00);
    wr(7'h1E, 8'h00);
    rdc(7'h1E, 16'h0000);
    foreach (tcfg[i])
    begin
      cfg(tcfg[i], dcfg[i]);
      run(36);
      drain();
      chk(exp_q.size(), 0);
    end
    // full buffer refuses samples, keeps its two words
    stall <= 1'b1;
    cfg(8'h00, 8'h00);
    n0 = nstrobe;
    run(6);
    chk(nstrobe - n0, 2);
    stall <= 1'b0;
    drain();
    chk(exp_q.size(), 0);
    // bias null on a still input; a frame meanwhile is ignored
    cfg(8'h00, 8'h04);
    cval = rsfbc_rate_t'($signed(rnd()) >>> 12);
    cmode = 1'b1;
    raw_rate <= cval;
    loose = 1'b1;
    ticking <= 1'b1;
    wr(7'h28, 8'h01);
    wr(7'h20, 8'h05);
    wait_busy();
    ticking <= 1'b0;
    repeat (40) @(posedge clk);
    drain();
    loose = 1'b0;
    off = -(cval + off);
    rdc(7'h08, off[15:0]);
    rdc(7'h0A, off[31:16]);
    rdc(7'h20, 16'h0000);
    // restore clears offsets and output words
    wr(7'h28, 8'h02);
    wait_busy();
    rdc(7'h08, 16'h0000);
    rdc(7'h0A, 16'h0000);
    rdc(7'h04, 16'h0000);
    rdc(7'h06, 16'h0000);
    test_done();
  end
endmodule : tb
